//--- core/srq_pkg.sv
// Constants and types for the request and control queue engine
package srq_pkg;
    // Response codes
    localparam logic [7:0] RSP_OK         = 8'h00;
    localparam logic [7:0] RSP_OVERRUN    = 8'h01;
    localparam logic [7:0] RSP_ABORTED    = 8'h02;
    localparam logic [7:0] RSP_BAD_TARGET = 8'h03;
    localparam logic [7:0] RSP_RESET      = 8'h04;
    localparam logic [7:0] RSP_BUSY       = 8'h05;
    localparam logic [7:0] RSP_TRANSPORT  = 8'h06;
    localparam logic [7:0] RSP_TARGET     = 8'h07;
    localparam logic [7:0] RSP_NEXUS      = 8'h08;
    localparam logic [7:0] RSP_FAILURE    = 8'h09;
    localparam logic [7:0] RSP_FN_DONE    = 8'h00;
    localparam logic [7:0] RSP_FN_OK      = 8'h0A;
    localparam logic [7:0] RSP_FN_REJECT  = 8'h0B;
    localparam logic [7:0] WRONG_UNIT_RESPONSE = 8'h0C;
    // Control types
    localparam logic [31:0] CTRL_TMF                    = 32'h0000_0000;
    localparam logic [31:0] NOTIFICATION_QUERY_TYPE     = 32'h0000_0001;
    localparam logic [31:0] NOTIFICATION_SUBSCRIBE_TYPE = 32'h0000_0002;
    // Management subtypes
    localparam logic [31:0] TMF_ABORT_TASK     = 32'h0000_0000;
    localparam logic [31:0] TMF_ABORT_TASK_SET = 32'h0000_0001;
    localparam logic [31:0] TMF_CLEAR_ACA      = 32'h0000_0002;
    localparam logic [31:0] TMF_CLEAR_TASK_SET = 32'h0000_0003;
    localparam logic [31:0] TMF_NEXUS_RESET    = 32'h0000_0004;
    localparam logic [31:0] TMF_UNIT_RESET     = 32'h0000_0005;
    localparam logic [31:0] TMF_QUERY_TASK     = 32'h0000_0006;
    localparam logic [31:0] TMF_QUERY_TASK_SET = 32'h0000_0007;
    // Task attributes
    localparam logic [7:0] ATTR_SIMPLE = 8'h00;
    localparam logic [7:0] ATTR_ORDERED = 8'h01;
    localparam logic [7:0] ATTR_HEAD = 8'h02;
    // Unit address layout
    localparam logic [7:0] LUN_FIRST_BYTE = 8'h01;
    localparam int         NUM_TARGETS    = 256;
    localparam int         UNITS_PER_TGT  = 16384;
    // Event bits
    localparam logic [31:0] EVT_OPER_CHANGE = 32'h0000_0002;
    localparam logic [31:0] EVT_POWER_MGMT  = 32'h0000_0004;
    localparam logic [31:0] EVT_EXT_REQUEST = 32'h0000_0008;
    localparam logic [31:0] EVT_MEDIA       = 32'h0000_0010;
    localparam logic [31:0] EVT_MULTI_HOST  = 32'h0000_0020;
    localparam logic [31:0] EVT_DEV_BUSY    = 32'h0000_0040;
    // Configuration defaults
    localparam logic [31:0] SENSE_SIZE_RST = 32'h0000_0060;
    localparam logic [31:0] CDB_SIZE_RST   = 32'h0000_0020;
    localparam int          FEAT_INOUT_BIT = 0;
    // Buffer depth
    localparam int BUF_DEPTH = 2;
    typedef enum logic [1:0] {
        SRQ_IDLE = 2'b00,
        SRQ_DATA = 2'b01,
        SRQ_RESP = 2'b11
    } srq_state_t;
endpackage : srq_pkg

//--- core/srq_engine.sv
// Request and control queue engine for a queue-based SCSI host
`timescale 1ns/10ps
// Functional notes
// - Unit address: byte0=1, byte1 target, bytes2-3 unit, last four zero.
// - All task attributes are treated as simple.
// - Sense length reports bytes actually written to sense buffer.
// - Residual is data length minus transferred, both directions summed; overrun responses report residual 0 instead.
// - Residual below inbound size only if outbound fully consumed; overrun reports 0 with no outbound byte consumed.
// - Status byte carries a standard SCSI status.
// - OK response whenever command completed, any status.
// - Overrun when command wants more data than buffers hold.
// - Aborted for abort functions, reset for reset cancellations; no request is taken while in SRQ_DATA, so no command is ever cancelled.
// - Bad target returned unprocessed for a missing target.
// - Transport, target, nexus and busy failures carry fixed codes.
// - Both directions without bidirectional feature fail at once.
// - Completion on arrival queue; cross-queue order left to driver.
// - Control responses use codes 9,10,11,12 plus OK and bad target.
// - Control type 0 decodes management subtypes.
// - Irrelevant fields ignored; unit ignored for nexus-wide functions.
// - Task functions match identifier against outstanding requests.
// - Function outcomes: complete 0, succeeded 10, rejected 11.
// - Query returns the requested events that the unit supports.
// - Subscribe registers events and returns supported subset.
// - Reset restores sense size 96 and command block size 32.
// - Feature bit 0 allows bidirectional requests.
module srq_engine #(
    parameter int QID_W   = 4,
    parameter int TAGS    = 4,
    parameter logic [31:0] SUPPORTED_EVENTS = 32'h0000_0012
) (
    input  wire logic              clk,            // 50 MHz clock
    input  wire logic              nrst,           // Async reset, low
    input  wire logic              en,             // Clock enable
    input  wire logic [31:0]       features,       // Negotiated features
    input  wire logic              cfg_wr,         // Config write strobe
    input  wire logic [31:0]       cfg_sense_size, // New sense size
    input  wire logic [31:0]       cfg_cdb_size,   // New command block size
    output logic      [31:0]       sense_size,     // Current sense size
    output logic      [31:0]       cdb_size,       // Current cdb size
    input  wire logic [255:0]      target_present, // Target map
    // Command request
    input  wire logic              req_valid,      // Request offered
    output logic                   req_ready,      // Request taken
    input  wire logic              req_is_ctrl,    // Control queue request
    input  wire logic [QID_W-1:0]  req_queue,      // Arrival queue
    input  wire logic [63:0]       req_lun,        // Unit address
    input  wire logic [63:0]       req_id,         // Command tag
    input  wire logic [7:0]        req_attr,       // Task attribute
    input  wire logic [31:0]       req_ctype,      // Control type
    input  wire logic [31:0]       req_subtype,    // Management subtype
    input  wire logic [31:0]       req_ev_req,     // Requested events
    input  wire logic [31:0]       req_out_len,    // Outbound buffer bytes
    input  wire logic [31:0]       req_in_len,     // Inbound buffer bytes
    input  wire logic [31:0]       req_need_len,   // Bytes the cdb demands
    // Backend result
    input  wire logic              be_valid,       // Backend completion
    input  wire logic [31:0]       be_out_done,    // Outbound bytes consumed
    input  wire logic [31:0]       be_in_done,     // Inbound bytes written
    input  wire logic [31:0]       be_sense_len,   // Sense bytes written
    input  wire logic [7:0]        be_status,      // SCSI status
    input  wire logic [7:0]        be_fail,        // Failure code or OK
    output logic                   be_start,       // Backend go pulse
    // Completion stream
    output logic                   cpl_valid,      // Completion offered
    input  wire logic              cpl_ready,      // Completion accepted
    output logic      [QID_W-1:0]  cpl_queue,      // Queue to complete on
    output logic      [31:0]       cpl_sense_len,  // Sense length word
    output logic      [31:0]       cpl_residual,   // Residual word
    output logic      [7:0]        cpl_status,     // Status byte
    output logic      [31:0]       cpl_ev_actual,  // Actual events word
    output logic      [7:0]        cpl_response,   // Response byte
    output logic      [31:0]       subscribed      // Subscribed event mask
);
    if (QID_W < 1 || TAGS < 1) begin : g_param_check
        $error("srq_engine: bad parameters");
    end
    localparam int CW = 32 + 32 + 8 + 32 + 8 + 32 + QID_W;

    // ------------------------------------------------
    // Functions
    // ------------------------------------------------
    // Address layout check
    function automatic logic lun_ok(input logic [63:0] l);
        lun_ok = (l[63:56] == srq_pkg::LUN_FIRST_BYTE) && (l[31:0] == 32'h0000_0000);
    endfunction : lun_ok

    // ------------------------------------------------
    // Decode
    // ------------------------------------------------
    logic [7:0]  tgt;
    logic        bidir, bidir_bad, tgt_bad, lun_bad, over;
    logic        tmf, is_q, is_s, nexus_fn;
    logic [31:0] ev_sup;
    assign tgt       = req_lun[55:48];
    assign bidir     = (req_out_len != 32'h0) && (req_in_len != 32'h0);
    assign bidir_bad = bidir && !features[srq_pkg::FEAT_INOUT_BIT];
    assign tgt_bad   = !target_present[tgt];
    assign lun_bad   = !lun_ok(req_lun);
    assign over      = req_need_len > (req_out_len + req_in_len);
    assign tmf       = req_ctype == srq_pkg::CTRL_TMF;
    assign is_q      = req_ctype == srq_pkg::NOTIFICATION_QUERY_TYPE;
    assign is_s      = req_ctype == srq_pkg::NOTIFICATION_SUBSCRIBE_TYPE;
    assign nexus_fn  = req_subtype == srq_pkg::TMF_NEXUS_RESET;
    assign ev_sup    = req_ev_req & SUPPORTED_EVENTS;

    // ------------------------------------------------
    // Outstanding tag table
    // ------------------------------------------------
    logic [63:0] tag_q [TAGS];
    logic [TAGS-1:0] tag_v_q;
    logic [TAGS-1:0] hit;
    logic            any_hit;
    always_comb begin
        for (int i = 0; i < TAGS; i++) hit[i] = tag_v_q[i] && (tag_q[i] == req_id);
    end
    assign any_hit = |hit;

    // ------------------------------------------------
    // Management outcome
    // ------------------------------------------------
    logic [7:0] tmf_rsp;
    always_comb begin
        unique case (req_subtype)
            srq_pkg::TMF_ABORT_TASK, srq_pkg::TMF_ABORT_TASK_SET,
            srq_pkg::TMF_CLEAR_TASK_SET, srq_pkg::TMF_NEXUS_RESET,
            srq_pkg::TMF_UNIT_RESET, srq_pkg::TMF_CLEAR_ACA:
                tmf_rsp = srq_pkg::RSP_FN_DONE;
            srq_pkg::TMF_QUERY_TASK:
                tmf_rsp = any_hit ? srq_pkg::RSP_FN_OK : srq_pkg::RSP_FN_DONE;
            srq_pkg::TMF_QUERY_TASK_SET:
                tmf_rsp = |tag_v_q ? srq_pkg::RSP_FN_OK : srq_pkg::RSP_FN_DONE;
            default:
                tmf_rsp = srq_pkg::RSP_FN_REJECT;
        endcase
    end
    logic [7:0] ctrl_rsp;
    always_comb begin
        if (tgt_bad)
            ctrl_rsp = srq_pkg::RSP_BAD_TARGET;
        else if (lun_bad && !(tmf && nexus_fn))
            ctrl_rsp = srq_pkg::WRONG_UNIT_RESPONSE;
        else if (tmf)
            ctrl_rsp = tmf_rsp;
        else if (is_q || is_s)
            ctrl_rsp = srq_pkg::RSP_OK;
        else
            ctrl_rsp = srq_pkg::RSP_FAILURE;
    end
    logic cancel_tmf, abort_kind;
    assign cancel_tmf = req_valid && req_ready && req_is_ctrl && tmf && !tgt_bad
                        && (req_subtype inside {srq_pkg::TMF_ABORT_TASK,
                            srq_pkg::TMF_ABORT_TASK_SET, srq_pkg::TMF_CLEAR_TASK_SET,
                            srq_pkg::TMF_NEXUS_RESET, srq_pkg::TMF_UNIT_RESET});
    assign abort_kind = req_subtype inside {srq_pkg::TMF_ABORT_TASK,
                                            srq_pkg::TMF_ABORT_TASK_SET};

    // ------------------------------------------------
    // Sequencer
    // ------------------------------------------------
    srq_pkg::srq_state_t st_q, st_d;
    logic [CW-1:0] res_q, res_d;
    logic [31:0]   datalen_q;
    logic          cancel_q, cancel_abort_q;
    logic          buf_ready;
    logic          push;
    logic [31:0]   xfer, resid;
    logic [7:0]    cmd_rsp;
    assign xfer  = be_out_done + be_in_done;
    assign resid = datalen_q - xfer;
    assign cmd_rsp = cancel_q ? (cancel_abort_q ? srq_pkg::RSP_ABORTED : srq_pkg::RSP_RESET)
                              : be_fail;
    logic          req_take;
    assign req_take = req_valid && req_ready;
    assign push = (st_q == srq_pkg::SRQ_RESP);

    always_comb begin
        st_d  = st_q;
        res_d = res_q;
        if (st_q == srq_pkg::SRQ_IDLE && req_take) begin
            st_d = srq_pkg::SRQ_RESP;
            if (req_is_ctrl)
                res_d = {32'h0, 32'h0, 8'h00, (is_q || is_s) ? ev_sup : 32'h0,
                         ctrl_rsp, 32'h0, req_queue};
            else if (bidir_bad)
                res_d = {32'h0, req_out_len + req_in_len, 8'h00, 32'h0,
                         srq_pkg::RSP_FAILURE, 32'h0, req_queue};
            else if (tgt_bad)
                res_d = {32'h0, req_out_len + req_in_len, 8'h00, 32'h0,
                         srq_pkg::RSP_BAD_TARGET, 32'h0, req_queue};
            else if (lun_bad)
                res_d = {32'h0, req_out_len + req_in_len, 8'h00, 32'h0,
                         srq_pkg::RSP_FAILURE, 32'h0, req_queue};
            else if (over)
                res_d = {32'h0, 32'h0, 8'h00, 32'h0, srq_pkg::RSP_OVERRUN, 32'h0, req_queue};
            else
                st_d = srq_pkg::SRQ_DATA;
        end else if (st_q == srq_pkg::SRQ_DATA && (be_valid || cancel_q)) begin
            st_d = srq_pkg::SRQ_RESP;
            res_d = {(be_sense_len > sense_size) ? sense_size : be_sense_len,
                     cancel_q ? datalen_q : resid, be_status, 32'h0, cmd_rsp, 32'h0,
                     res_q[QID_W-1:0]};
        end else if (st_q == srq_pkg::SRQ_RESP) begin
            st_d = srq_pkg::SRQ_IDLE;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= srq_pkg::SRQ_IDLE;
            res_q <= '0;
            datalen_q <= 32'h0;
            be_start <= 1'b0;
            cancel_q <= 1'b0;
            cancel_abort_q <= 1'b0;
            tag_v_q <= '0;
            req_ready <= 1'b0;
            sense_size <= srq_pkg::SENSE_SIZE_RST;
            cdb_size <= srq_pkg::CDB_SIZE_RST;
            subscribed <= 32'h0;
        end else if (en) begin
            st_q <= st_d;
            res_q <= res_d;
            req_ready <= (st_d == srq_pkg::SRQ_IDLE) && buf_ready;
            be_start <= (st_q == srq_pkg::SRQ_IDLE) && (st_d == srq_pkg::SRQ_DATA);
            if (cfg_wr) begin
                sense_size <= cfg_sense_size;
                cdb_size <= cfg_cdb_size;
            end
            if (req_take && req_is_ctrl && is_s && ctrl_rsp == srq_pkg::RSP_OK)
                subscribed <= ev_sup;
            if (st_q == srq_pkg::SRQ_IDLE && st_d == srq_pkg::SRQ_DATA) begin
                datalen_q <= req_out_len + req_in_len;
                res_q[QID_W-1:0] <= req_queue;
                tag_v_q[0] <= 1'b1;
                tag_q[0] <= req_id;
                cancel_q <= 1'b0;
            end else if (st_q == srq_pkg::SRQ_RESP) begin
                tag_v_q[0] <= 1'b0;
            end
            if (cancel_tmf && st_q == srq_pkg::SRQ_DATA && (!(req_subtype ==
                srq_pkg::TMF_ABORT_TASK) || hit[0])) begin
                cancel_q <= 1'b1;
                cancel_abort_q <= abort_kind;
            end
        end
    end

    // ------------------------------------------------
    // Completion buffer, two entries
    // ------------------------------------------------
    logic [CW-1:0] buf_q [srq_pkg::BUF_DEPTH];
    logic [1:0]    wp_q, rp_q;
    logic          pop;
    assign pop       = cpl_valid && cpl_ready;
    // Room after this edge's push and pop, so no push meets a full buffer
    assign buf_ready = (wp_q - rp_q + {1'b0, push} - {1'b0, pop}) != 2'd2;
    // Response word emitted last with its queue
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wp_q <= 2'd0;
            rp_q <= 2'd0;
        end else if (en) begin
            if (push) begin
                buf_q[wp_q[0]] <= res_q;
                wp_q <= wp_q + 2'd1;
            end
            if (pop) rp_q <= rp_q + 2'd1;
        end
    end
    assign {cpl_sense_len, cpl_residual, cpl_status, cpl_ev_actual, cpl_response,
            cpl_queue_pad, cpl_queue} = buf_q[rp_q[0]];
    logic [31:0] cpl_queue_pad;
    assign cpl_valid = wp_q != rp_q;

    // ------------------------------------------------
    // Assertions
    // ------------------------------------------------
    // checked on the first clock edge after reset is released, whatever en is
    sense_default_a: assert property (@(posedge clk) $rose(nrst) |-> sense_size == 32'h60)
        else $error("sense size not default after reset");
    bidir_fail_a: assert property (@(posedge clk) disable iff (!nrst)
        en && req_take && !req_is_ctrl && bidir_bad |=>
        res_q[QID_W+39:QID_W+32] == srq_pkg::RSP_FAILURE)
        else $error("bidirectional request did not fail");
    bad_tgt_a: assert property (@(posedge clk) disable iff (!nrst)
        en && req_take && !req_is_ctrl && !bidir_bad && tgt_bad |=>
        res_q[QID_W+39:QID_W+32] == srq_pkg::RSP_BAD_TARGET)
        else $error("missing target not reported");
    bad_unit_a: assert property (@(posedge clk) disable iff (!nrst)
        en && req_take && !req_is_ctrl && !bidir_bad && !tgt_bad && lun_bad |=>
        res_q[QID_W+39:QID_W+32] == srq_pkg::RSP_FAILURE)
        else $error("malformed unit address not refused");
    overrun_rsp_a: assert property (@(posedge clk) disable iff (!nrst)
        en && req_take && !req_is_ctrl && !bidir_bad && !tgt_bad && !lun_bad && over |=>
        res_q[QID_W+39:QID_W+32] == srq_pkg::RSP_OVERRUN)
        else $error("overrun not reported");
    sequence s_backend_done;
        en && st_q == srq_pkg::SRQ_DATA && be_valid && !cancel_q;
    endsequence
    sequence s_outcome_kept;
        st_q == srq_pkg::SRQ_RESP && res_q[QID_W+39:QID_W+32] == $past(be_fail);
    endsequence
    cmd_rsp_a: assert property (@(posedge clk) disable iff (!nrst)
        s_backend_done |=> s_outcome_kept)
        else $error("backend outcome not passed to response");
    cpl_hold_a: assert property (@(posedge clk) disable iff (!nrst)
        cpl_valid && !cpl_ready |=> cpl_valid && $stable(cpl_response) && $stable(cpl_queue))
        else $error("completion changed before it was taken");
endmodule : srq_engine

//--- test/srq_backend_model.sv
// Backend model that answers go pulses after a chosen delay
`timescale 1ns/10ps
module srq_backend_model (
    input  wire logic         clk,      // Clock
    input  wire logic         nrst,     // Async reset, low
    input  wire logic         be_start, // Go pulse
    input  wire logic [7:0]   lat,      // Cycles before answering
    input  wire logic [111:0] res,      // Result fields to return
    output logic              be_valid, // Completion pulse
    output logic [111:0]      be_res    // Result fields, scrambled when idle
);
    logic [7:0] cnt_q;
    logic       busy_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_q   <= 1'b0;
            cnt_q    <= 8'h00;
            be_valid <= 1'b0;
            be_res   <= '1;
        end else begin
            be_valid <= 1'b0;
            be_res   <= ~be_res;
            if (be_start) begin
                busy_q <= 1'b1;
                cnt_q  <= lat;
            end else if (busy_q && cnt_q == 8'h00) begin
                busy_q   <= 1'b0;
                be_valid <= 1'b1;
                be_res   <= res;
            end else if (busy_q) begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : srq_backend_model

//--- test/srq_engine_test.sv
// Self-checking bench for the request and control queue engine
`timescale 1ns/10ps
module srq_engine_test;
    localparam logic [31:0] SUP = 32'h0000_0052;
    logic         clk, nrst, en, cfg_wr, req_valid, req_is_ctrl, cpl_ready, ok;
    logic         req_ready, be_valid, be_start, cpl_valid;
    logic [31:0]  features, cfg_sense_size, cfg_cdb_size, sense_size, cdb_size;
    logic [31:0]  req_ctype, req_subtype, req_ev_req, req_out_len, req_in_len, req_need_len;
    logic [31:0]  cpl_sense_len, cpl_residual, cpl_ev_actual, subscribed, e_res, e_ev;
    logic [255:0] target_present;
    logic [3:0]   req_queue, cpl_queue;
    logic [63:0]  req_lun, req_id;
    logic [7:0]   req_attr, cpl_status, cpl_response, lat, e_rsp, e_st, fl;
    logic [111:0] res, be_res;
    logic [15:0]  rnd;
    int           errors, samples_checked, acc, e_kind, cat;
    logic [7:0]   fails [5] = '{8'h00, 8'h05, 8'h06, 8'h07, 8'h08};

    srq_engine #(.QID_W(4), .TAGS(4), .SUPPORTED_EVENTS(SUP)) u_dut (
        .clk(clk), .nrst(nrst), .en(en), .features(features), .cfg_wr(cfg_wr),
        .cfg_sense_size(cfg_sense_size), .cfg_cdb_size(cfg_cdb_size),
        .sense_size(sense_size), .cdb_size(cdb_size), .target_present(target_present),
        .req_valid(req_valid), .req_ready(req_ready), .req_is_ctrl(req_is_ctrl),
        .req_queue(req_queue), .req_lun(req_lun), .req_id(req_id), .req_attr(req_attr),
        .req_ctype(req_ctype), .req_subtype(req_subtype), .req_ev_req(req_ev_req),
        .req_out_len(req_out_len), .req_in_len(req_in_len), .req_need_len(req_need_len),
        .be_valid(be_valid), .be_out_done(be_res[111:80]), .be_in_done(be_res[79:48]),
        .be_sense_len(be_res[47:16]), .be_status(be_res[15:8]), .be_fail(be_res[7:0]),
        .be_start(be_start), .cpl_valid(cpl_valid), .cpl_ready(cpl_ready),
        .cpl_queue(cpl_queue), .cpl_sense_len(cpl_sense_len), .cpl_residual(cpl_residual),
        .cpl_status(cpl_status), .cpl_ev_actual(cpl_ev_actual),
        .cpl_response(cpl_response), .subscribed(subscribed));

    srq_backend_model u_be (.clk(clk), .nrst(nrst), .be_start(be_start), .lat(lat),
        .res(res), .be_valid(be_valid), .be_res(be_res));

    initial clk = 1'b0;
    always #10 clk = ~clk;

    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr

    function automatic logic [63:0] mklun(input logic [7:0] tgt, input logic [13:0] unit);
        return {8'h01, tgt, 2'b01, unit[13:8], unit[7:0], 32'h0000_0000};
    endfunction : mklun

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : chk

    task automatic end_sim();
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_sim

    task automatic send(output logic taken);
        int n;
        taken = 1'b0;
        req_valid = 1'b1;
        for (n = 0; n < 40 && !taken; n++) begin
            if (req_ready === 1'b1) taken = 1'b1;
            @(negedge clk);
        end
        req_valid = 1'b0;
        @(negedge clk);
    endtask : send

    task automatic take();
        int n;
        n = 0;
        while (cpl_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk("cpl_arrived", {31'h0, cpl_valid}, 32'h0000_0001);
        repeat (rnd[1:0]) @(negedge clk);
        chk("cpl_held", {31'h0, cpl_valid}, 32'h0000_0001);
        chk("cpl_queue", {28'h0, cpl_queue}, {28'h0, req_queue});
        if (e_kind == 3)
            chk("tmf_outcome", {31'h0, cpl_response inside {8'h00, 8'h0A, 8'h0B}}, 1);
        else
            chk("cpl_response", {24'h0, cpl_response}, {24'h0, e_rsp});
        if (e_kind == 1) begin
            chk("cpl_residual", cpl_residual, e_res);
            chk("cpl_sense_len", cpl_sense_len, res[47:16]);
            chk("cpl_status", {24'h0, cpl_status}, {24'h0, e_st});
        end
        if (e_kind == 2) chk("cpl_ev_actual", cpl_ev_actual, e_ev);
        cpl_ready = 1'b1;
        @(negedge clk);
        cpl_ready = 1'b0;
        @(negedge clk);
    endtask : take

    task automatic defaults();
        chk("sense_size", sense_size, 32'h0000_0060);
        chk("cdb_size", cdb_size, 32'h0000_0020);
    endtask : defaults

    initial begin
        repeat (40000) @(posedge clk);
        errors++;
        end_sim();
    end

    initial begin
        {nrst, cfg_wr, req_valid, req_is_ctrl, cpl_ready} = '0;
        en = 1'b1;
        features = '0;
        {cfg_sense_size, cfg_cdb_size, req_ctype, req_subtype, req_ev_req} = '0;
        {req_out_len, req_in_len, req_need_len, req_queue, req_lun, req_id, req_attr} = '0;
        target_present = {128{2'b01}};
        lat = 8'h00;
        res = '0;
        rnd = 16'h6E0C;
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        defaults();
        cfg_wr = 1'b1;
        cfg_sense_size = 32'h0000_0040;
        cfg_cdb_size = 32'h0000_0010;
        @(negedge clk);
        cfg_wr = 1'b0;
        @(negedge clk);
        chk("sense_size_wr", sense_size, 32'h0000_0040);
        repeat (60) begin
            rnd = lfsr(rnd);
            cat = int'(rnd[6:0]) % 5;
            req_is_ctrl = 1'b0;
            req_queue = rnd[11:8];
            req_id = {48'h0, rnd};
            req_attr = 8'h00;
            req_lun = mklun({rnd[14:8], 1'b0}, {rnd[5:0], rnd[15:8]});
            req_out_len = {24'h0, rnd[15:8]} + 32'h1;
            req_in_len = {24'h0, rnd[7:0]} + 32'h1;
            req_need_len = req_out_len + req_in_len;
            features = 32'h0000_0001;
            fl = fails[int'(rnd[12:8]) % 5];
            e_st = {rnd[4:0], 3'b000};
            res = {req_out_len, req_in_len >> 1, 26'h0, rnd[5:0], e_st, fl};
            lat = {3'b000, rnd[14:10]};
            e_res = req_in_len - (req_in_len >> 1);
            e_kind = 0;
            case (cat)
                0: begin
                    e_kind = 1;
                    e_rsp = fl;
                    req_attr = {6'h00, rnd[9:8]};
                end
                1: begin
                    req_lun[55:48] = {rnd[14:8], 1'b1};
                    e_rsp = srq_pkg::RSP_BAD_TARGET;
                end
                2: begin
                    req_lun[63:56] = 8'h02;
                    e_rsp = srq_pkg::RSP_FAILURE;
                end
                3: begin
                    features = 32'h0000_0000;
                    e_rsp = srq_pkg::RSP_FAILURE;
                end
                default: begin
                    req_need_len = req_need_len + 32'h1;
                    e_rsp = srq_pkg::RSP_OVERRUN;
                end
            endcase
            // each request sent once, never retried
            send(ok);
            take();
        end
        req_is_ctrl = 1'b1;
        req_ctype = srq_pkg::CTRL_TMF;
        for (int st = 0; st < 9; st++) begin
            rnd = lfsr(rnd);
            req_subtype = st;
            req_lun = mklun({rnd[14:8], 1'b0}, {rnd[5:0], rnd[15:8]});
            e_kind = 3;
            send(ok);
            take();
        end
        req_lun[55:48] = 8'h03;
        e_kind = 0;
        e_rsp = srq_pkg::RSP_BAD_TARGET;
        send(ok);
        take();
        req_lun[55:48] = 8'h04;
        req_ctype = srq_pkg::NOTIFICATION_QUERY_TYPE;
        req_ev_req = 32'h0000_007E;
        e_kind = 2;
        e_rsp = srq_pkg::RSP_OK;
        e_ev = SUP;
        send(ok);
        take();
        req_ctype = srq_pkg::NOTIFICATION_SUBSCRIBE_TYPE;
        req_ev_req = {16'h0, rnd} & 32'h0000_007E;
        e_ev = req_ev_req & SUP;
        send(ok);
        take();
        chk("subscribed", subscribed, e_ev);
        // Offer four requests to the completion buffer, counting those taken, then drain
        req_is_ctrl = 1'b0;
        req_lun = mklun(8'h05, 14'h0001);
        features = 32'h0000_0001;
        e_kind = 0;
        e_rsp = srq_pkg::RSP_BAD_TARGET;
        acc = 0;
        for (int k = 0; k < 4; k++) begin
            send(ok);
            if (ok) acc++;
        end
        chk("buffer_filled", {31'h0, acc >= srq_pkg::BUF_DEPTH && acc < 4}, 1);
        for (int k = 0; k < acc; k++) take();
        nrst = 1'b0;
        @(negedge clk);
        nrst = 1'b1;
        @(negedge clk);
        defaults();
        end_sim();
    end
endmodule : srq_engine_test
